// ==== cnco_pkg.sv ====
// Constants, register map and carrier types for the carrier NCO and mixer
// Behaviour
// - Frequency word is center plus offset, modulo 2^32, driving a 32-bit accumulator.
// - Offset-zero bit in control word 0 replaces the serial offset with zero.
// - Accumulator advances only on clocks with the sample enable asserted low.
// - Frequency word is two's complement, spanning minus to plus half sample rate.
// - Ten-bit phase offset adds to accumulator MSBs, wrapping over one cycle.
// - Phase offset is low ten bits of its word, -512 to 511, 1/1024 cycle.
// - Top 18 phase bits address a sine/cosine generator with 18-bit amplitude.
// - Mixer multiplies 14-bit sample by 18-bit cosine for I, sine for Q.
// - Each product is rounded symmetrically to 15 bits.
// - Center frequency and phase offset writes land in holding registers only.
// - Write to the center transfer address copies center holding into active.
// - Write to the phase transfer address copies phase holding into active.
// - With sync-update enabled, front-end sync transfers both holding registers.
// - With accumulator-clear set, a transfer zeroes the accumulator feedback.
// - Serial word width is 8, 16, 24 or 32 bits per loader field.
// - Serial data arrive MSB first and shift in on each rising edge.
// - Word sync starts a countdown; when done the shift register loads the hold.
// - Short words sit in hold MSBs with the low bits cleared.
// - Carrier loader runs on the input clock; resampler loader on the back-end clock. Here both loaders run on the core clock.
// - Serial words may follow back to back with no idle clocks.
package cnco_pkg;
   localparam int CNCO_ADDR_W = 8;
   localparam int CNCO_CORDIC_N = 16;
   localparam logic [7:0] CNCO_A_CTRL0 = 8'h00;
   localparam logic [7:0] CNCO_A_CTRL1 = 8'h01;
   localparam logic [7:0] CNCO_A_CENTER = 8'h03;
   localparam logic [7:0] CNCO_A_PHASE = 8'h04;
   localparam logic [7:0] CNCO_A_XFER_CF = 8'h05;
   localparam logic [7:0] CNCO_A_XFER_PO = 8'h06;
   localparam logic [7:0] CNCO_A_CTRL11 = 8'h0B;
   localparam logic [7:0] CNCO_A_ACT_CF = 8'h10;
   localparam logic [7:0] CNCO_A_ACT_PO = 8'h11;
   localparam logic [7:0] CNCO_A_COF_HOLD = 8'h12;
   localparam logic [7:0] CNCO_A_SOF_HOLD = 8'h13;
   localparam logic [7:0] CNCO_A_ACC = 8'h14;
   localparam logic [7:0] CNCO_A_STATUS = 8'h15;
   localparam int CNCO_B_ACC_CLR = 0;
   localparam int CNCO_B_OFS_ZERO = 1;
   localparam int CNCO_B_CW_LO = 4;
   localparam int CNCO_B_SYNC_EN = 20;
   localparam int CNCO_B_SW_LO = 3;
   localparam logic [31:0] CNCO_CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] CNCO_FREQ_RST = 32'h0000_0000;
   localparam logic [9:0] CNCO_PO_RST = 10'h000;
   localparam logic [5:0] CNCO_BITS_STEP = 6'h08;
   localparam logic [5:0] CNCO_BITS_FULL = 6'h20;
   localparam logic signed [19:0] CNCO_X0 = 20'sh136EA;
   localparam logic [17:0] CNCO_HALF_TURN = 18'h20000;
   localparam logic [17:0] CNCO_ATAN [CNCO_CORDIC_N] = '{
      18'h08000, 18'h04B90, 18'h027ED, 18'h01444, 18'h00A2C, 18'h00517,
      18'h0028C, 18'h00146, 18'h000A3, 18'h00051, 18'h00029, 18'h00014,
      18'h0000A, 18'h00005, 18'h00003, 18'h00001};
   localparam logic signed [32:0] CNCO_RND_POS = 33'sh0_0000_8000;
   localparam logic signed [32:0] CNCO_RND_NEG = 33'sh0_0000_7FFF;
   localparam logic signed [16:0] CNCO_OUT_MAX = 17'sh03FFF;
   localparam logic signed [16:0] CNCO_OUT_MIN = 17'sh1C000;
   localparam logic signed [19:0] CNCO_LUT_MAX = 20'sh1FFFF;
   localparam logic signed [19:0] CNCO_LUT_MIN = 20'shE0001;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } cnco_bus_s;

   typedef struct packed {
      logic signed [14:0] i;
      logic signed [14:0] q;
   } cnco_iq_s;
endpackage

// ==== cnco_top.sv ====
// Carrier NCO with serial offset loaders, sine/cosine generator and quadrature mixer
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module cnco_top
(
   input wire logic CORE_CLK_I,
   input wire logic RST_B_I,
   input wire cnco_pkg::cnco_bus_s REG_REQ_I,
   output logic [31:0] REG_RDATA_O,
   input wire logic signed [13:0] SAMPLE_I,
   input wire logic INPUT_SAMPLE_ENABLE_N_I,
   input wire logic FRONT_END_SYNC_IN_I,
   input wire logic CARRIER_OFFSET_SERIAL_DATA_I,
   input wire logic CARRIER_OFFSET_WORD_SYNC_I,
   input wire logic SAMPLE_OFFSET_SERIAL_DATA_I,
   input wire logic SAMPLE_OFFSET_WORD_SYNC_I,
   output cnco_pkg::cnco_iq_s MIX_O,
   output logic MIX_VALID_O,
   output logic [31:0] SAMPLE_OFFSET_FREQ_O
);

   logic [31:0] ctrl0, ctrl1, ctrl11, cf_hold, cf_act, acc, freq_word, rd_val;
   logic [9:0] po_hold, po_act, phase_msb;
   logic sync_prev, sync_edge, xfer_cf, xfer_po, acc_clr, v1;
   logic [1:0] ser_d, ser_s, ld_busy;
   logic [1:0] ld_code [2];
   logic [31:0] ofs_hold [2];
   logic [17:0] lut_addr;
   logic signed [17:0] cos_w, sin_w, cos_r, sin_r;
   logic signed [13:0] samp_r;
   logic signed [31:0] prod_i, prod_q;

   default clocking cb @(posedge CORE_CLK_I);
   endclocking
   default disable iff (!RST_B_I);

   function automatic logic wr_to(input cnco_pkg::cnco_bus_s r, input logic [7:0] a);
      return r.wr && (r.addr == a);
   endfunction

   function automatic logic [5:0] width_bits(input logic [1:0] code);
      return {1'b0, code, 3'b000} + cnco_pkg::CNCO_BITS_STEP;
   endfunction

   function automatic logic signed [17:0] sat18(input logic signed [19:0] v);
      if (v > cnco_pkg::CNCO_LUT_MAX)
      begin
         return cnco_pkg::CNCO_LUT_MAX[17:0];
      end
      else if (v < cnco_pkg::CNCO_LUT_MIN)
      begin
         return cnco_pkg::CNCO_LUT_MIN[17:0];
      end
      return v[17:0];
   endfunction

   function automatic logic signed [14:0] rnd15(input logic signed [31:0] p);
      logic signed [32:0] s;
      logic signed [16:0] t;
      s = {p[31], p} + (p[31] ? cnco_pkg::CNCO_RND_NEG : cnco_pkg::CNCO_RND_POS);
      t = s[32:16];
      if (t > cnco_pkg::CNCO_OUT_MAX)
      begin
         return cnco_pkg::CNCO_OUT_MAX[14:0];
      end
      else if (t < cnco_pkg::CNCO_OUT_MIN)
      begin
         return cnco_pkg::CNCO_OUT_MIN[14:0];
      end
      return t[14:0];
   endfunction

   // Control words
   always_ff @(posedge CORE_CLK_I)
   begin
      if (!RST_B_I)
      begin
         ctrl0 <= cnco_pkg::CNCO_CTRL_RST;
         ctrl1 <= cnco_pkg::CNCO_CTRL_RST;
         ctrl11 <= cnco_pkg::CNCO_CTRL_RST;
      end
      else
      begin
         if (wr_to(REG_REQ_I, cnco_pkg::CNCO_A_CTRL0))
         begin
            ctrl0 <= REG_REQ_I.wdata;
         end
         if (wr_to(REG_REQ_I, cnco_pkg::CNCO_A_CTRL1))
         begin
            ctrl1 <= REG_REQ_I.wdata;
         end
         if (wr_to(REG_REQ_I, cnco_pkg::CNCO_A_CTRL11))
         begin
            ctrl11 <= REG_REQ_I.wdata;
         end
      end
   end

   // Holding registers
   always_ff @(posedge CORE_CLK_I)
   begin
      if (!RST_B_I)
      begin
         cf_hold <= cnco_pkg::CNCO_FREQ_RST;
         po_hold <= cnco_pkg::CNCO_PO_RST;
      end
      else
      begin
         if (wr_to(REG_REQ_I, cnco_pkg::CNCO_A_CENTER))
         begin
            cf_hold <= REG_REQ_I.wdata;
         end
         if (wr_to(REG_REQ_I, cnco_pkg::CNCO_A_PHASE))
         begin
            po_hold <= REG_REQ_I.wdata[9:0];
         end
      end
   end

   // Transfer requests from software or the sync pin
   assign sync_edge = FRONT_END_SYNC_IN_I && !sync_prev;
   assign xfer_cf = wr_to(REG_REQ_I, cnco_pkg::CNCO_A_XFER_CF) ||
                    (ctrl1[cnco_pkg::CNCO_B_SYNC_EN] && sync_edge);
   assign xfer_po = wr_to(REG_REQ_I, cnco_pkg::CNCO_A_XFER_PO) ||
                    (ctrl1[cnco_pkg::CNCO_B_SYNC_EN] && sync_edge);
   assign acc_clr = (xfer_cf || xfer_po) && ctrl0[cnco_pkg::CNCO_B_ACC_CLR];

   always_ff @(posedge CORE_CLK_I)
   begin
      if (!RST_B_I)
      begin
         sync_prev <= 1'b0;
         cf_act <= cnco_pkg::CNCO_FREQ_RST;
         po_act <= cnco_pkg::CNCO_PO_RST;
      end
      else
      begin
         sync_prev <= FRONT_END_SYNC_IN_I;
         if (xfer_cf)
         begin
            cf_act <= cf_hold;
         end
         if (xfer_po)
         begin
            po_act <= po_hold;
         end
      end
   end

   // Serial offset loaders: carrier on index 0, resampler on index 1
   assign ser_d = {SAMPLE_OFFSET_SERIAL_DATA_I, CARRIER_OFFSET_SERIAL_DATA_I};
   assign ser_s = {SAMPLE_OFFSET_WORD_SYNC_I, CARRIER_OFFSET_WORD_SYNC_I};
   assign ld_code[0] = ctrl0[cnco_pkg::CNCO_B_CW_LO +: 2];
   assign ld_code[1] = ctrl11[cnco_pkg::CNCO_B_SW_LO +: 2];

   for (genvar k = 0; k < 2; k++)
   begin : g_ld
      logic [31:0] shreg;
      logic [31:0] shifted;
      logic [31:0] hold;
      logic [5:0] cnt;
      logic [5:0] nbits;
      logic busy;

      assign shifted = {shreg[30:0], ser_d[k]};
      assign ofs_hold[k] = hold;
      assign ld_busy[k] = busy;

      // Both loaders share the core clock here
      always_ff @(posedge CORE_CLK_I)
      begin
         if (!RST_B_I)
         begin
            shreg <= 32'h0000_0000;
            hold <= 32'h0000_0000;
            cnt <= 6'h00;
            nbits <= 6'h00;
            busy <= 1'b0;
         end
         else
         begin
            if (busy)
            begin
               shreg <= shifted;
               cnt <= cnt - 6'h01;
               if (cnt == 6'h01)
               begin
                  hold <= shifted << (cnco_pkg::CNCO_BITS_FULL - nbits);
               end
            end
            if (ser_s[k])
            begin
               busy <= 1'b1;
               cnt <= width_bits(ld_code[k]);
               nbits <= width_bits(ld_code[k]);
               shreg <= 32'h0000_0000;
            end
            else if (busy && (cnt == 6'h01))
            begin
               busy <= 1'b0;
            end
         end
      end

      sequence s_word8;
         (ser_s[k] && (ld_code[k] == 2'h0)) ##1 (!ser_s[k]) [*8];
      endsequence
      property p_ld_done;
         s_word8 |=> (hold[31:24] == $past({shreg[6:0], ser_d[k]}));
      endproperty
      a_ld_done: assert property (p_ld_done) else $error("serial word not loaded");
      property p_ld_pad;
         s_word8 |=> (hold[23:0] == 24'h000000);
      endproperty
      a_ld_pad: assert property (p_ld_pad) else $error("short word low bits not cleared");
      property p_ld_chain;
         (busy && (cnt == 6'h01) && ser_s[k]) |=> (busy && (cnt == nbits));
      endproperty
      a_ld_chain: assert property (p_ld_chain) else $error("back to back word lost");
   end

   assign SAMPLE_OFFSET_FREQ_O = ofs_hold[1];

   // Frequency word; wraps as two's complement
   assign freq_word = cf_act +
      (ctrl0[cnco_pkg::CNCO_B_OFS_ZERO] ? 32'h0000_0000 : ofs_hold[0]);

   always_ff @(posedge CORE_CLK_I)
   begin
      if (!RST_B_I)
      begin
         acc <= 32'h0000_0000;
      end
      else if (acc_clr)
      begin
         acc <= 32'h0000_0000;
      end
      else if (!INPUT_SAMPLE_ENABLE_N_I)
      begin
         acc <= acc + freq_word;
      end
   end

   // Phase offset on the MSBs, wraps modulo one turn
   assign phase_msb = acc[31:22] + po_act;
   assign lut_addr = {phase_msb, acc[21:14]};

   // Sine/cosine generator over the full 18-bit phase
   always_comb
   begin
      logic flip;
      logic [17:0] pa;
      logic signed [19:0] x;
      logic signed [19:0] y;
      logic signed [19:0] z;
      logic signed [19:0] xn;
      logic signed [19:0] at;
      flip = lut_addr[17] ^ lut_addr[16];
      pa = flip ? (lut_addr ^ cnco_pkg::CNCO_HALF_TURN) : lut_addr;
      z = {{2{pa[17]}}, pa};
      x = cnco_pkg::CNCO_X0;
      y = 20'sh00000;
      xn = 20'sh00000;
      at = 20'sh00000;
      for (int i = 0; i < cnco_pkg::CNCO_CORDIC_N; i++)
      begin
         at = {2'b00, cnco_pkg::CNCO_ATAN[i]};
         if (z < 0)
         begin
            xn = x + (y >>> i);
            y = y - (x >>> i);
            z = z + at;
         end
         else
         begin
            xn = x - (y >>> i);
            y = y + (x >>> i);
            z = z - at;
         end
         x = xn;
      end
      cos_w = sat18(flip ? -x : x);
      sin_w = sat18(flip ? -y : y);
   end

   // Mixer stage one: sample and quadrature pair
   always_ff @(posedge CORE_CLK_I)
   begin
      if (!RST_B_I)
      begin
         samp_r <= 14'sh0000;
         cos_r <= 18'sh00000;
         sin_r <= 18'sh00000;
         v1 <= 1'b0;
      end
      else
      begin
         v1 <= !INPUT_SAMPLE_ENABLE_N_I;
         if (!INPUT_SAMPLE_ENABLE_N_I)
         begin
            samp_r <= SAMPLE_I;
            cos_r <= cos_w;
            sin_r <= sin_w;
         end
      end
   end

   assign prod_i = samp_r * cos_r;
   assign prod_q = samp_r * sin_r;

   // Mixer stage two: rounded outputs
   always_ff @(posedge CORE_CLK_I)
   begin
      if (!RST_B_I)
      begin
         MIX_O <= '0;
         MIX_VALID_O <= 1'b0;
      end
      else
      begin
         MIX_VALID_O <= v1;
         if (v1)
         begin
            MIX_O.i <= rnd15(prod_i);
            MIX_O.q <= rnd15(prod_q);
         end
      end
   end

   // Register read port
   always_comb
   begin
      unique case (REG_REQ_I.addr)
         cnco_pkg::CNCO_A_CTRL0: rd_val = ctrl0;
         cnco_pkg::CNCO_A_CTRL1: rd_val = ctrl1;
         cnco_pkg::CNCO_A_CTRL11: rd_val = ctrl11;
         cnco_pkg::CNCO_A_ACT_CF: rd_val = cf_act;
         cnco_pkg::CNCO_A_ACT_PO: rd_val = {22'h0, po_act};
         cnco_pkg::CNCO_A_COF_HOLD: rd_val = ofs_hold[0];
         cnco_pkg::CNCO_A_SOF_HOLD: rd_val = ofs_hold[1];
         cnco_pkg::CNCO_A_ACC: rd_val = acc;
         cnco_pkg::CNCO_A_STATUS: rd_val = {30'h0, ld_busy};
         default: rd_val = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge CORE_CLK_I)
   begin
      if (!RST_B_I)
      begin
         REG_RDATA_O <= 32'h0000_0000;
      end
      else
      begin
         REG_RDATA_O <= REG_REQ_I.rd ? rd_val : 32'h0000_0000;
      end
   end

   property p_acc_hold;
      (INPUT_SAMPLE_ENABLE_N_I && !acc_clr) |=> $stable(acc);
   endproperty
   a_acc_hold: assert property (p_acc_hold) else $error("accumulator moved while idle");
   property p_acc_step;
      (!INPUT_SAMPLE_ENABLE_N_I && !acc_clr) |=> (acc == $past(acc) + $past(freq_word));
   endproperty
   a_acc_step: assert property (p_acc_step) else $error("accumulator step wrong");
   property p_ofs_zero;
      ctrl0[cnco_pkg::CNCO_B_OFS_ZERO] |-> (freq_word == cf_act);
   endproperty
   a_ofs_zero: assert property (p_ofs_zero) else $error("offset not zeroed");
   property p_acc_clear;
      acc_clr |=> (acc == 32'h0000_0000);
   endproperty
   a_acc_clear: assert property (p_acc_clear) else $error("accumulator not cleared");
   property p_cf_xfer;
      wr_to(REG_REQ_I, cnco_pkg::CNCO_A_XFER_CF) |=> (cf_act == $past(cf_hold));
   endproperty
   a_cf_xfer: assert property (p_cf_xfer) else $error("center transfer failed");
   property p_po_xfer;
      wr_to(REG_REQ_I, cnco_pkg::CNCO_A_XFER_PO) |=> (po_act == $past(po_hold));
   endproperty
   a_po_xfer: assert property (p_po_xfer) else $error("phase transfer failed");
   property p_sync_xfer;
      (ctrl1[cnco_pkg::CNCO_B_SYNC_EN] && FRONT_END_SYNC_IN_I && !sync_prev) |=>
         ((cf_act == $past(cf_hold)) && (po_act == $past(po_hold)));
   endproperty
   a_sync_xfer: assert property (p_sync_xfer) else $error("sync transfer failed");
   property p_hold_only;
      !xfer_cf |=> $stable(cf_act);
   endproperty
   a_hold_only: assert property (p_hold_only) else $error("active center changed");
   sequence s_take;
      !INPUT_SAMPLE_ENABLE_N_I;
   endsequence
   property p_mix_latency;
      s_take |-> ##2 MIX_VALID_O;
   endproperty
   a_mix_latency: assert property (p_mix_latency) else $error("mixer output late");
endmodule

// ==== cnco_src.sv ====
// Serial offset word source model for the two-pin offset loaders
`timescale 1ns/1ps
module cnco_src
(
   input wire logic clk_i,
   output logic data_o,
   output logic sync_o,
   output logic idle_o
);
   logic [31:0] w_q[$];
   int n_q[$];
   logic [31:0] w;
   int n;
   initial
   begin
      data_o = 1'b0;
      sync_o = 1'b0;
      idle_o = 1'b1;
      n = 0;
   end
   task automatic push(input logic [31:0] wd, input int nb);
      w_q.push_back(wd);
      n_q.push_back(nb);
   endtask
   always @(posedge clk_i)
   begin
      sync_o <= 1'b0;
      if (n > 0)
      begin
         data_o <= w[31];
         w = w << 1;
         n = n - 1;
      end
      else
         data_o <= ~data_o;
      if (n == 0 && w_q.size() > 0)
      begin
         sync_o <= 1'b1;
         w = w_q.pop_front();
         n = n_q.pop_front();
      end
      idle_o <= (n == 0) && (w_q.size() == 0);
   end
endmodule

// ==== tb_cnco_top.sv ====
// Self-checking testbench for the carrier NCO and mixer
`timescale 1ns/1ps
module tb_cnco_top;
   logic clk = 1'b0;
   logic rst_b;
   cnco_pkg::cnco_bus_s req;
   logic [31:0] rdata;
   logic signed [13:0] smp;
   logic en_n;
   logic fsync;
   logic cd, cs, ci, sd, ss, si;
   cnco_pkg::cnco_iq_s mix;
   logic mv;
   logic [31:0] sof;
   int errors = 0;
   int total_checks = 0;
   int seed = 9;
   logic [31:0] cf, ofs, acc, w;
   always #20 clk = ~clk;
   cnco_src i_src_c (.clk_i(clk), .data_o(cd), .sync_o(cs), .idle_o(ci));
   cnco_src i_src_s (.clk_i(clk), .data_o(sd), .sync_o(ss), .idle_o(si));
   cnco_top i_cnco_top (.CORE_CLK_I(clk), .RST_B_I(rst_b), .REG_REQ_I(req),
      .REG_RDATA_O(rdata), .SAMPLE_I(smp), .INPUT_SAMPLE_ENABLE_N_I(en_n),
      .FRONT_END_SYNC_IN_I(fsync), .CARRIER_OFFSET_SERIAL_DATA_I(cd),
      .CARRIER_OFFSET_WORD_SYNC_I(cs), .SAMPLE_OFFSET_SERIAL_DATA_I(sd),
      .SAMPLE_OFFSET_WORD_SYNC_I(ss), .MIX_O(mix), .MIX_VALID_O(mv),
      .SAMPLE_OFFSET_FREQ_O(sof));
   task automatic end_sim();
      $display("Checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic near(input string nm, input real e, input logic signed [14:0] g);
      int ei;
      ei = int'(e);
      total_checks++;
      if ((^g === 1'bx) || (int'(g) - ei > 4) || (ei - int'(g) > 4))
      begin
         errors++;
         $display("CHECK FAILED %s expected %0d seen %0d", nm, ei, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      #1;
      chk(nm, e, rdata);
   endtask
   task automatic run(input int n);
      @(posedge clk);
      en_n <= 1'b0;
      repeat (n)
      begin
         @(posedge clk);
         smp <= 14'($random(seed));
      end
      en_n <= 1'b1;
   endtask
   task automatic pulse();
      @(posedge clk);
      fsync <= 1'b1;
      @(posedge clk);
      fsync <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic wait_idle(input logic s);
      repeat (2) @(posedge clk);
      for (int k = 0; k < 100 && !(s ? si : ci); k++)
         @(posedge clk);
      chk("src_idle", 32'h1, 32'(s ? si : ci));
      repeat (2) @(posedge clk);
   endtask
   initial
   begin
      #2000000;
      errors++;
      end_sim();
   end
   initial
   begin
      int pl[5] = '{0, 256, 512, 32, 768};
      int nb;
      real a;
      logic signed [13:0] s;
      rst_b = 1'b0;
      req = '0;
      smp = '0;
      en_n = 1'b1;
      fsync = 1'b0;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      for (int r = 8'h10; r < 8'h16; r++)
         rdc("reset", 8'(r), 32'h0);
      rdc("unmapped", 8'h7F, 32'h0);
      $display("TEST reset done");
      for (int c = 3; c >= 0; c--)
      begin
         nb = 8 * (c + 1);
         wr(cnco_pkg::CNCO_A_CTRL0, 32'(c) << cnco_pkg::CNCO_B_CW_LO);
         w = $random(seed);
         i_src_c.push(w << (32 - nb), nb);
         w = $random(seed);
         ofs = w << (32 - nb);
         i_src_c.push(ofs, nb);
         wait_idle(1'b0);
         rdc("cof_hold", cnco_pkg::CNCO_A_COF_HOLD, ofs);
      end
      wr(cnco_pkg::CNCO_A_CTRL11, 32'h1 << cnco_pkg::CNCO_B_SW_LO);
      w = $random(seed);
      i_src_s.push(w << 16, 16);
      wait_idle(1'b1);
      chk("sof", w << 16, sof);
      $display("TEST serial done");
      cf = $random(seed) | 32'h8000_0000;
      wr(cnco_pkg::CNCO_A_CENTER, cf);
      rdc("act_cf", cnco_pkg::CNCO_A_ACT_CF, 32'h0);
      rdc("cf_wo", cnco_pkg::CNCO_A_CENTER, 32'h0);
      wr(cnco_pkg::CNCO_A_XFER_CF, 32'h0);
      rdc("act_cf", cnco_pkg::CNCO_A_ACT_CF, cf);
      run(5);
      acc = 32'd5 * (cf + ofs);
      rdc("acc", cnco_pkg::CNCO_A_ACC, acc);
      wr(cnco_pkg::CNCO_A_CTRL0, 32'h1 << cnco_pkg::CNCO_B_OFS_ZERO);
      run(3);
      acc = acc + 32'd3 * cf;
      rdc("acc_ofz", cnco_pkg::CNCO_A_ACC, acc);
      wr(cnco_pkg::CNCO_A_PHASE, 32'h200);
      rdc("act_po", cnco_pkg::CNCO_A_ACT_PO, 32'h0);
      wr(cnco_pkg::CNCO_A_XFER_PO, 32'h0);
      rdc("act_po", cnco_pkg::CNCO_A_ACT_PO, 32'h200);
      $display("TEST nco done");
      wr(cnco_pkg::CNCO_A_CENTER, ~cf);
      wr(cnco_pkg::CNCO_A_PHASE, 32'h155);
      pulse();
      rdc("no_sync", cnco_pkg::CNCO_A_ACT_CF, cf);
      wr(cnco_pkg::CNCO_A_CTRL1, 32'h1 << cnco_pkg::CNCO_B_SYNC_EN);
      wr(cnco_pkg::CNCO_A_CTRL0, 32'h3);
      run(2);
      pulse();
      rdc("sync_cf", cnco_pkg::CNCO_A_ACT_CF, ~cf);
      rdc("sync_po", cnco_pkg::CNCO_A_ACT_PO, 32'h155);
      rdc("acc_clr", cnco_pkg::CNCO_A_ACC, 32'h0);
      $display("TEST sync done");
      wr(cnco_pkg::CNCO_A_CENTER, 32'h0);
      wr(cnco_pkg::CNCO_A_XFER_CF, 32'h0);
      foreach (pl[k])
      begin
         wr(cnco_pkg::CNCO_A_PHASE, 32'(pl[k]));
         wr(cnco_pkg::CNCO_A_XFER_PO, 32'h0);
         s = 14'($random(seed));
         @(posedge clk);
         en_n <= 1'b0;
         smp <= s;
         @(posedge clk);
         en_n <= 1'b1;
         #1;
         chk("valid_c1", 32'h0, 32'(mv));
         @(posedge clk);
         #1;
         chk("valid_c2", 32'h1, 32'(mv));
         a = 6.283185307179586 * pl[k] / 1024.0;
         near("mix_i", s * $cos(a) * 131071.0 / 65536.0, mix.i);
         near("mix_q", s * $sin(a) * 131071.0 / 65536.0, mix.q);
         @(posedge clk);
         #1;
         chk("valid_c3", 32'h0, 32'(mv));
      end
      $display("TEST mixer done");
      end_sim();
   end
endmodule
